// ---- verilog/flash_cmd_pkg.sv ----
// Constants for the flash store command handler
package flash_cmd_pkg;
  localparam logic [7:0]  CMD_GEOMETRY_QUERY = 8'h00;
  localparam logic [7:0]  CMD_ERASE          = 8'h01;
  localparam logic [7:0]  RSP_GEOMETRY_REPLY = 8'h80;
  localparam logic [7:0]  RSP_ERASE_REPLY    = 8'h81;
  localparam logic [7:0]  RSP_CODE_FLAG      = 8'h80;
  localparam logic [7:0]  CLUSTER_MEMORY     = 8'h23;
  localparam logic [7:0]  ENDPOINT_DEVICE    = 8'hE6;
  localparam logic [15:0] STORE_BLOCKS       = 16'h0077;
  localparam logic [15:0] BLOCK_BYTES        = 16'h0200;
  localparam int          HEADER_BYTES       = 8;
  localparam int          OFS_CODE           = 0;
  localparam int          OFS_OPTION         = 1;
  localparam int          OFS_BLOCK          = 2;
  localparam int          OFS_INDEX          = 4;
  localparam int          OFS_COUNT          = 6;
  localparam int          STATUS_ERR_BIT     = 0;
  localparam logic [7:0]  STATUS_OK          = 8'h00;
  localparam logic [7:0]  STATUS_FAIL        = 8'h01;
endpackage

// ---- verilog/response_serializer.sv ----
// Serialises the eight-byte response header most significant byte first
`timescale 1ns/1ps
module response_serializer (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [7:0]  code,
  input  wire logic [7:0]  status,
  input  wire logic [15:0] block,
  input  wire logic [15:0] index,
  input  wire logic [15:0] count,
  output logic             busy,
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  output logic             rsp_last,
  input  wire logic        rsp_ready
);
  import flash_cmd_pkg::*;
  logic [63:0] shift_q;
  logic [3:0]  left_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 64'h0;
      left_q  <= 4'h0;
    end else if (load && left_q == 4'h0) begin
      shift_q <= {code, status, block, index, count};
      left_q  <= 4'(HEADER_BYTES);
    end else if (rsp_valid && rsp_ready) begin
      shift_q <= {shift_q[55:0], 8'h00};
      left_q  <= left_q - 4'h1;
    end
  end

  assign busy      = left_q != 4'h0;
  assign rsp_valid = busy;
  assign rsp_data  = shift_q[63:56];
  assign rsp_last  = left_q == 4'h1;
endmodule

// ---- verilog/flash_store_command_handler.sv ----
// Command interpreter for the block-organised flash store
// Notes on behaviour
// - Request: code, option, block number, byte index, count, then data bytes.
// - Two-byte fields travel most significant byte first.
// - Unicast request gets a unicast reply to the request's source endpoint.
// - Broadcast requests get no reply at all.
// - Reply layout mirrors request; offset 1 is status; code is reply code.
// - Count gives following data bytes, or requested bytes for a read.
// - Source endpoint 0xE6 or explicit mode means reply shown as explicit frame.
// - Geometry reply 0x80: block count, block size, count zero.
// - Status bit 0 marks failure; higher bits read zero.
// - Code 0x01 erases whole blocks to all ones.
// - Erase with count zero wipes every block, block number ignored.
// - Store holds 119 blocks of 512 bytes, reported by geometry reply.
// - Erase reply 0x81 echoes block and index, count zero.
`timescale 1ns/1ps
module flash_store_command_handler
#(
  parameter logic [15:0] BLOCKS     = flash_cmd_pkg::STORE_BLOCKS,
  parameter logic [15:0] BLOCK_SIZE = flash_cmd_pkg::BLOCK_BYTES
)
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  req_data,
  input  wire logic        req_valid,
  input  wire logic        req_last,
  input  wire logic        req_broadcast,
  input  wire logic [7:0]  req_src_endpoint,
  output logic             req_ready,
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  output logic             rsp_last,
  input  wire logic        rsp_ready,
  output logic [7:0]       rsp_dst_endpoint,
  output logic             rsp_explicit,
  output logic [15:0]      erase_block,
  output logic             erase_req,
  input  wire logic        erase_done,
  input  wire logic        explicit_mode
);
  import flash_cmd_pkg::*;

  typedef enum logic [2:0] {ST_RECV, ST_DRAIN, ST_EXEC, ST_ERASE, ST_WAIT, ST_REPLY} state_t;

  state_t      state_q;
  logic [63:0] hdr_q;
  logic [3:0]  cnt_q;
  logic        bcast_q;
  logic [7:0]  src_q;
  logic [7:0]  code_q;
  logic [7:0]  status_q;
  logic [15:0] rblock_q;
  logic [15:0] rindex_q;
  logic [15:0] blk_q;
  logic [15:0] last_blk_q;
  logic        load;
  logic        ser_busy;
  logic        short_q;
  logic [3:0]  sent_q;
  logic [15:0] pulses_q;

  wire [7:0]  f_code  = hdr_q[63:56];
  wire [15:0] f_block = hdr_q[47:32];
  wire [15:0] f_index = hdr_q[31:16];
  wire [15:0] f_count = hdr_q[15:0];

  // Decided combinationally so the state walk never reads a stale status byte
  function automatic logic erase_out_of_range(input logic [15:0] count, input logic [15:0] block);
    return count != 16'h0 && block >= BLOCKS;
  endfunction

  assign req_ready = state_q == ST_RECV || state_q == ST_DRAIN;
  assign load      = state_q == ST_REPLY;

  // Header bytes shift in; data bytes past the header are consumed and dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_q   <= 64'h0;
      cnt_q   <= 4'h0;
      bcast_q <= 1'b0;
      src_q   <= 8'h00;
      short_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      if (cnt_q < 4'(HEADER_BYTES)) begin
        hdr_q <= {hdr_q[55:0], req_data};
        cnt_q <= cnt_q + 4'h1;
      end
      if (cnt_q == 4'h0) begin
        bcast_q <= req_broadcast;
        src_q   <= req_src_endpoint;
      end
      if (req_last) begin
        cnt_q <= 4'h0;
        // Frame ended inside the header
        short_q <= cnt_q < 4'(HEADER_BYTES - 1);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RECV;
    end else begin
      unique case (state_q)
        ST_RECV: begin
          if (req_valid && req_last) begin
            // Short frames fall here too and are rejected in ST_EXEC
            state_q <= ST_EXEC;
          end
        end
        ST_DRAIN: begin
          state_q <= ST_RECV;
        end
        ST_EXEC: begin
          if (short_q) begin
            state_q <= ST_RECV;
          end else if (f_code == CMD_ERASE && !erase_out_of_range(f_count, f_block)) begin
            state_q <= ST_ERASE;
          end else if (bcast_q) begin
            state_q <= ST_RECV;
          end else begin
            state_q <= ST_REPLY;
          end
        end
        ST_ERASE: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (erase_done) begin
            if (blk_q != last_blk_q) begin
              state_q <= ST_ERASE;
            end else if (bcast_q) begin
              state_q <= ST_RECV;
            end else begin
              state_q <= ST_REPLY;
            end
          end
        end
        ST_REPLY: begin
          if (!ser_busy) begin
            state_q <= ST_RECV;
          end
        end
        default: state_q <= ST_RECV;
      endcase
    end
  end

  // Reply fields, decided in ST_EXEC once the last request byte has arrived
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      code_q   <= 8'h00;
      status_q <= STATUS_OK;
      rblock_q <= 16'h0;
      rindex_q <= 16'h0;
    end else if (state_q == ST_RECV && req_valid && req_last) begin
      status_q <= STATUS_OK;
      code_q   <= req_data | RSP_CODE_FLAG;
    end else if (state_q == ST_EXEC) begin
      code_q   <= f_code | RSP_CODE_FLAG;
      rindex_q <= f_index;
      rblock_q <= f_block;
      if (f_code == CMD_GEOMETRY_QUERY) begin
        rblock_q <= BLOCKS;
        rindex_q <= BLOCK_SIZE;
        status_q <= STATUS_OK;
      end else if (f_code == CMD_ERASE) begin
        if (erase_out_of_range(f_count, f_block)) begin
          status_q <= STATUS_FAIL;
        end else begin
          status_q <= STATUS_OK;
        end
      end else begin
        // Write and read are not handled here
        status_q <= STATUS_FAIL;
      end
    end
  end

  // Erase walks one block at a time through the flash port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blk_q      <= 16'h0;
      last_blk_q <= 16'h0;
    end else if (state_q == ST_EXEC) begin
      if (f_count == 16'h0) begin
        blk_q      <= 16'h0;
        last_blk_q <= BLOCKS - 16'h1;
      end else begin
        blk_q      <= f_block;
        last_blk_q <= f_block;
      end
    end else if (state_q == ST_WAIT && erase_done && blk_q != last_blk_q) begin
      blk_q <= blk_q + 16'h1;
    end
  end

  assign erase_req   = state_q == ST_ERASE;
  assign erase_block = blk_q;

  // Counts accepted reply bytes, so the length check needs no long repetition
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sent_q <= 4'h0;
    end else if (rsp_valid && rsp_ready) begin
      sent_q <= rsp_last ? 4'h0 : sent_q + 4'h1;
    end
  end

  // Counts erase pulses of one command
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulses_q <= 16'h0;
    end else if (state_q == ST_EXEC) begin
      pulses_q <= 16'h0;
    end else if (erase_req) begin
      pulses_q <= pulses_q + 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_dst_endpoint <= 8'h00;
      rsp_explicit     <= 1'b0;
    end else if (load && !ser_busy) begin
      rsp_dst_endpoint <= src_q;
      rsp_explicit     <= src_q == ENDPOINT_DEVICE || explicit_mode;
    end
  end

  response_serializer u_ser (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .load      (load && !ser_busy),
    .code      (code_q),
    .status    (status_q),
    .block     (rblock_q),
    .index     (rindex_q),
    .count     (16'h0),
    .busy      (ser_busy),
    .rsp_data  (rsp_data),
    .rsp_valid (rsp_valid),
    .rsp_last  (rsp_last),
    .rsp_ready (rsp_ready)
  );

  a_erase_one_block: assert property (@(posedge mclk) disable iff (!reset_n)
    erase_req |-> ##1 !erase_req) else $error("erase request longer than one cycle");
  a_range_check: assert property (@(posedge mclk) disable iff (!reset_n)
    erase_req |-> erase_block < BLOCKS) else $error("erase beyond store");
  a_status_bits: assert property (@(posedge mclk) disable iff (!reset_n)
    status_q[7:1] == 7'h0) else $error("reserved status bits set");
  a_bcast_silent: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_EXEC && bcast_q |=> !load) else $error("broadcast answered");
  a_reply_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    rsp_valid && !$past(rsp_valid) |-> rsp_data[7]) else $error("reply code flag missing");
  a_reply_len: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(rsp_valid) && rsp_ready |=> rsp_valid) else $error("reply too short");
  a_geom_vals: assert property (@(posedge mclk) disable iff (!reset_n)
    load && code_q == RSP_GEOMETRY_REPLY && status_q == STATUS_OK |-> rblock_q == BLOCKS && rindex_q == BLOCK_SIZE)
    else $error("geometry values wrong");
  a_dst_echo: assert property (@(posedge mclk) disable iff (!reset_n)
    load && !ser_busy |=> rsp_dst_endpoint == $past(src_q)) else $error("reply endpoint wrong");
  a_short_drop: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_EXEC && short_q |=> state_q == ST_RECV) else $error("short frame executed");
  a_range_no_erase: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_EXEC && f_code == CMD_ERASE && erase_out_of_range(f_count, f_block) |=> !erase_req)
    else $error("erase beyond store started");
  a_range_status: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_EXEC && f_code == CMD_ERASE && erase_out_of_range(f_count, f_block)
    |=> status_q == STATUS_FAIL) else $error("range error not flagged");
  a_erase_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_WAIT && !erase_done |=> $stable(erase_block)) else $error("erase block moved early");
  a_walk_end: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_WAIT && erase_done && blk_q == last_blk_q |=> !erase_req) else $error("erase walk overran");
  a_walk_count: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_WAIT && erase_done && blk_q == last_blk_q
    |-> pulses_q == (f_count == 16'h0 ? BLOCKS : 16'h1)) else $error("wrong number of blocks erased");
  a_wait_silent: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == ST_WAIT && erase_done && bcast_q && blk_q == last_blk_q |=> !load)
    else $error("broadcast erase answered");
  a_explicit_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    load && !ser_busy |=> rsp_explicit == ($past(src_q) == ENDPOINT_DEVICE || $past(explicit_mode)))
    else $error("explicit flag wrong");
  a_count_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    rsp_valid && rsp_last |-> rsp_data == 8'h00) else $error("reply count not zero");
  a_erase_echo: assert property (@(posedge mclk) disable iff (!reset_n)
    load && code_q == RSP_ERASE_REPLY |-> rblock_q == f_block && rindex_q == f_index)
    else $error("erase reply fields not echoed");
  a_reply_eight: assert property (@(posedge mclk) disable iff (!reset_n)
    rsp_valid && rsp_ready && rsp_last |-> sent_q == 4'(HEADER_BYTES - 1)) else $error("reply not eight bytes");

  c_geometry: cover property (@(posedge mclk) load && code_q == RSP_GEOMETRY_REPLY);
  c_erase_all: cover property (@(posedge mclk) erase_req && erase_block == BLOCKS - 16'h1);
  c_erase_err: cover property (@(posedge mclk) load && status_q == STATUS_FAIL);
  c_short_drop: cover property (@(posedge mclk) state_q == ST_EXEC && short_q);
  c_bcast_erase: cover property (@(posedge mclk) state_q == ST_WAIT && erase_done && bcast_q);
endmodule

// ---- tb/flash_array_model.sv ----
// Behavioural flash array acknowledging each block erase
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       erase_req,
  input  wire logic [3:0] latency,
  output logic            erase_done
);
  int wait_q;

  // One acknowledge per whole block; latency varies to stress the handshake
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q     <= 0;
      erase_done <= 1'b0;
    end else begin
      erase_done <= (wait_q == 1);
      if (erase_req)
        wait_q <= int'(latency) + 1;
      else if (wait_q != 0)
        wait_q <= wait_q - 1;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the flash store command handler
`timescale 1ns/1ps
module tb;
  import flash_cmd_pkg::*;
  logic        mclk;
  logic        reset_n;
  logic [7:0]  req_data;
  logic        req_valid;
  logic        req_last;
  logic        req_broadcast;
  logic [7:0]  req_src_endpoint;
  logic        req_ready;
  logic [7:0]  rsp_data;
  logic        rsp_valid;
  logic        rsp_last;
  logic        rsp_ready;
  logic [7:0]  rsp_dst_endpoint;
  logic        rsp_explicit;
  logic [15:0] erase_block;
  logic        erase_req;
  logic        erase_done;
  logic        explicit_mode;
  logic [3:0]  latency;
  logic [15:0] blk;
  logic [7:0]  ep;
  int          failures;
  int          num_checks;
  int          seed;
  int          nbyte;
  logic [8:0]  byte_q[$];
  logic [8:0]  dest_q[$];
  logic [15:0] blk_q[$];

  flash_store_command_handler dut (.mclk(mclk), .reset_n(reset_n), .req_data(req_data), .req_valid(req_valid),
    .req_last(req_last), .req_broadcast(req_broadcast), .req_src_endpoint(req_src_endpoint),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
    .rsp_ready(rsp_ready), .rsp_dst_endpoint(rsp_dst_endpoint), .rsp_explicit(rsp_explicit),
    .erase_block(erase_block), .erase_req(erase_req), .erase_done(erase_done), .explicit_mode(explicit_mode));
  flash_array_model array_model (.mclk(mclk), .reset_n(reset_n), .erase_req(erase_req), .latency(latency),
    .erase_done(erase_done));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Sends len payload bytes, notes the reply, waits for it to drain
  // Each frame stands for one addressed to the memory cluster on the device endpoint
  task automatic frame(input logic [63:0] f, input logic bc, input logic [7:0] src, input logic [63:0] rsp,
                       input int len);
    int i;
    int n;
    @(posedge mclk) #1;
    req_broadcast = bc;
    req_src_endpoint = src;
    for (i = 0; i < len; i++) begin
      if (i < HEADER_BYTES) req_data = f[63-8*i -: 8];
      else req_data = 8'(i);
      req_last = (i == len - 1);
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(posedge mclk) #1;
      @(posedge mclk) #1;
    end
    req_valid = 1'b0;
    req_last = 1'b0;
    check({15'h0000, req_ready}, 16'h0000, "ready after last byte");
    if (!bc && len >= HEADER_BYTES) begin
      dest_q.push_back({src == ENDPOINT_DEVICE || explicit_mode, src});
      for (i = 0; i < 8; i++) byte_q.push_back({i == 7, rsp[63-8*i -: 8]});
    end
    n = 0;
    while ((byte_q.size() != 0 || blk_q.size() != 0) && n < 2000) begin
      @(posedge mclk) #1;
      n++;
    end
    if (n == 2000) check(16'h0001, 16'h0000, "no reply");
  endtask

  always @(posedge mclk) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (byte_q.size() == 0) check(16'h0001, 16'h0000, "reply");
      else begin
        if (nbyte == 0) check({7'h00, rsp_explicit, rsp_dst_endpoint}, {7'h00, dest_q.pop_front()}, "dest");
        check({7'h00, rsp_last, rsp_data}, {7'h00, byte_q.pop_front()}, "reply byte");
        nbyte = (nbyte + 1) % 8;
      end
    end
    if (erase_req === 1'b1) begin
      if (blk_q.size() == 0) check(16'h0001, 16'h0000, "erase");
      else check(erase_block, blk_q.pop_front(), "erase block");
    end
  end

  // Random back-pressure and flash latency
  always @(posedge mclk) begin
    #1;
    rsp_ready = ($random(seed) & 3) != 0;
    latency = 4'($random(seed));
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    print_verdict;
  end

  initial begin
    seed = 32'h6762;
    failures = 0;
    num_checks = 0;
    nbyte = 0;
    reset_n = 1'b0;
    req_data = 8'h00;
    req_valid = 1'b0;
    req_last = 1'b0;
    req_broadcast = 1'b0;
    req_src_endpoint = 8'h00;
    rsp_ready = 1'b0;
    explicit_mode = 1'b0;
    latency = 4'h0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    frame(64'h0, 1'b0, 8'hE6, {RSP_GEOMETRY_REPLY, STATUS_OK, STORE_BLOCKS, BLOCK_BYTES, 16'h0000}, 8);
    frame(64'h0, 1'b1, 8'hE6, 64'h0, 8);
    frame(64'h0, 1'b0, 8'hE6, 64'h0, 5);
    blk_q.push_back(16'h002A);
    frame({CMD_ERASE, 8'h00, 16'h002A, 16'h0000, BLOCK_BYTES}, 1'b0, 8'h10,
          {RSP_ERASE_REPLY, STATUS_OK, 16'h002A, 32'h0}, 8);
    blk_q.push_back(STORE_BLOCKS - 16'h0001);
    frame({CMD_ERASE, 8'h00, STORE_BLOCKS - 16'h0001, 16'h0000, BLOCK_BYTES}, 1'b0, 8'h10,
          {RSP_ERASE_REPLY, STATUS_OK, STORE_BLOCKS - 16'h0001, 32'h0}, 8);
    explicit_mode = 1'b1;
    frame({CMD_ERASE, 8'h00, STORE_BLOCKS, 16'h0000, BLOCK_BYTES}, 1'b0, 8'h11,
          {RSP_ERASE_REPLY, STATUS_FAIL, STORE_BLOCKS, 32'h0}, 8);
    explicit_mode = 1'b0;
    frame({8'h02, 8'h00, 16'h0016, 16'h0003, 16'h0002}, 1'b0, 8'h20,
          {8'h82, STATUS_FAIL, 16'h0016, 16'h0003, 16'h0000}, 10);
    blk_q.push_back(16'h0005);
    frame({CMD_ERASE, 8'h00, 16'h0005, 16'h0000, BLOCK_BYTES}, 1'b1, 8'h30, 64'h0, 8);
    blk = 16'((($random(seed)) & 32'h7F) % 119);
    ep = 8'($random(seed)) | 8'h01;
    for (int i = 0; i < 119; i++) blk_q.push_back(16'(i));
    frame({CMD_ERASE, 8'h00, blk, 16'h0000, 16'h0000}, 1'b0, ep,
          {RSP_ERASE_REPLY, STATUS_OK, blk, 32'h0}, 8);
    print_verdict;
  end
endmodule
